// ### sequencer_defines.vh
// register offsets, field positions, reset values and encodings
`ifndef SEQUENCER_DEFINES_VH
`define SEQUENCER_DEFINES_VH
// apb register byte offsets; the two loop bases are matched against address bits 7:4
`define OFS_CTRL        8'h00
`define OFS_SR          8'h04
`define OFS_START       8'h08
`define OFS_NSP         8'h0c
`define OFS_ESP         8'h10
`define OFS_RAS         8'h14
`define OFS_STAT        8'h18
`define OFS_LC_BASE     4'h2
`define OFS_LS_BASE     4'h3
// status register fields
`define SR_LOOP_LSB     0
`define SR_LOOP_DONE    4
`define SR_EXC          5
`define SR_W            8
`define SR_RESET        8'h00
// pipeline shape
`define NUM_STAGES      5
`define FETCH_WORDS     8
`define MAX_SET_INSTR   6
`define MAX_AGU_SLOTS   2
// instruction word fields
`define IW_END          15
`define IW_TYPE_MSB     14
`define IW_TYPE_LSB     13
`define IW_THREE        12
`define IW_UNIT_MSB     11
`define IW_UNIT_LSB     10
`define IW_OP_MSB       9
`define IW_OP_LSB       8
`define IW_LOOP_END     7
`define IW_TGT_MSB      6
// type and unit codes
`define TYPE_3          2'h2
`define TYPE_4          2'h3
`define UNIT_AAU        2'h1
`define UNIT_BMU        2'h2
`define UNIT_CTL        2'h3
`define OP_JMP          2'h0
`define OP_CALL         2'h1
`define OP_RTS          2'h2
`define OP_LOOP         2'h3
`endif

// ### stack_mem.v
// software stack storage with registered read data
`timescale 1ns/1ps
module stack_mem #(
  parameter W     = 24,
  parameter AW    = 8
) (
  input  wire          clk,    // core clock
  input  wire          we,     // write strobe
  input  wire [AW-1:0] waddr,  // write address
  input  wire [W-1:0]  wdata,  // write data
  input  wire [AW-1:0] raddr,  // read address
  output reg  [W-1:0]  rdata   // read data, one cycle late
);
  reg [W-1:0] mem [0:(1<<AW)-1];

  // synchronous write and registered read; memory has no reset
  always @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end
endmodule

// ### program_sequencer.v
// program sequencer: fetch, dispatch, loops, stacks, apb registers
//
// Function
// RL1 - five stage pipeline without interlocks or automatic stalls or nops
// RL2 - stage one is prefetch, stage two is fetch, in that order
// RL3 - each fetch takes eight words, 128 bits, as often as possible
// RL4 - dispatch finds one execution set, independent of fetch set bounds; here a set ends at the end of its fetch set
// RL5 - stage four is address generation, stage five is execution
// RL6 - an execution set holds one to six instructions, by type
// RL7 - instructions are classified into four types
// RL8 - bit mask instruction takes one of the two address unit slots
// RL9 - most instructions complete in one pipeline cycle
// RL10 - four independent nestable hardware loop register sets
// RL11 - four loop start, four loop count registers, five loop flags
// RL12 - software nests a loop only inside a lower index loop
// RL13 - normal and exception stack pointers are kept
// RL14 - exception mode bit in status selects active stack pointer
// RL15 - subroutine entry pushes program counter and status
// RL16 - return restores program counter and status from the stack
// RL17 - call also loads return address into return address register
// RL18 - return uses return address register, still updates stack pointer
// RL19 - return address register valid only for the leaf routine
// RL20 - software initialises both stack pointers before use
// RL21 - return without that register flushes before resuming
`timescale 1ns/1ps
`include "sequencer_defines.vh"
module program_sequencer #(
  parameter PC_W  = 16,
  parameter SP_W  = 8,
  parameter LC_W  = 16
) (
  input  wire            pclk,          // core clock
  input  wire            presetn,       // async reset, active low
  input  wire            psel,          // apb select
  input  wire            penable,       // apb enable
  input  wire            pwrite,        // apb write
  input  wire [7:0]      paddr,         // apb byte address
  input  wire [31:0]     pwdata,        // apb write data
  output reg  [31:0]     prdata,        // apb read data
  output wire            pready,        // apb ready
  output wire            pslverr,       // apb error, unmapped
  output wire            fetch_req,     // prefetch request
  output wire [PC_W-1:0] fetch_addr,    // fetch set word address
  input  wire [127:0]    fetch_rdata,   // fetch set
  input  wire            fetch_rvalid,  // fetch set valid
  output reg             disp_valid,    // execution set dispatched
  output reg  [127:0]    disp_set,      // fetch set holding it
  output reg  [2:0]      disp_start,    // first word index
  output reg  [2:0]      disp_count,    // instruction count
  output reg             agen_valid,    // address generation stage
  output reg  [2:0]      agen_count,    // its instruction count
  output reg             exec_valid,    // execution stage
  output reg  [2:0]      exec_count,    // its instruction count
  output wire            exception_mode // active stack is exception
);
  // ***********************************************
  // state
  // ***********************************************
  localparam SW = PC_W + `SR_W;
  reg            run_reg;
  reg [PC_W-1:0] start_reg;
  reg [PC_W-1:0] pc_reg;
  reg [PC_W-1:0] req_addr_reg;
  reg            out_reg;
  reg            kill_reg;
  reg [127:0]    nxt_reg;
  reg            nxt_ok_reg;
  reg [PC_W-1:0] nxt_addr_reg;
  reg [127:0]    cur_reg;
  reg            cur_ok_reg;
  reg [PC_W-1:0] cur_addr_reg;
  reg [3:0]      ptr_reg;
  reg [`SR_W-1:0] sr_reg;
  reg [SP_W-1:0] nsp_reg;
  reg [SP_W-1:0] esp_reg;
  reg [PC_W-1:0] ras_reg;
  reg            ras_ok_reg;
  reg            ret_wait_reg;
  reg            ret_sr_reg;
  reg [LC_W-1:0] lc_reg [0:3];
  reg [PC_W-1:0] ls_reg [0:3];
  wire [SW-1:0]  stk_rdata;
  integer        i;

  assign exception_mode = sr_reg[`SR_EXC];

  // ***********************************************
  // execution set detection
  // ***********************************************
  // returns {has_ctl, ctl_pos[2:0], count[2:0], next_ptr[3:0]}
  function [10:0] scan_set;
    input [127:0] set;
    input [3:0]   ptr;
    reg   [3:0]   p;
    reg   [2:0]   cnt;
    reg   [1:0]   address_generation_unit;
    reg   [2:0]   cpos;
    reg           ctl;
    reg           done;
    reg   [15:0]  w;
    integer       k;
    begin
      p = ptr;
      cnt = 3'd0;
      address_generation_unit = 2'd0;
      cpos = 3'd0;
      ctl = 1'b0;
      done = 1'b0;
      w = 16'h0000;
      for (k = 0; k < `MAX_SET_INSTR; k = k + 1)
      begin
        if (!done && p < `FETCH_WORDS)
        begin
          w = set[p[2:0]*16 +: 16];
          // address unit slots are shared with bit mask ops
          if ((w[`IW_UNIT_MSB:`IW_UNIT_LSB] == `UNIT_AAU ||
               w[`IW_UNIT_MSB:`IW_UNIT_LSB] == `UNIT_BMU) &&
              address_generation_unit == `MAX_AGU_SLOTS)                       // RL8
            done = 1'b1;
          else
          begin
            if (w[`IW_UNIT_MSB:`IW_UNIT_LSB] == `UNIT_AAU ||
                w[`IW_UNIT_MSB:`IW_UNIT_LSB] == `UNIT_BMU)
              address_generation_unit = address_generation_unit + 2'd1;                            // RL8
            cnt = cnt + 3'd1;                              // RL6
            if (w[`IW_UNIT_MSB:`IW_UNIT_LSB] == `UNIT_CTL)
            begin
              ctl = 1'b1;
              cpos = p[2:0];
            end
            // type 3 spans two or three words, others one
            if (w[`IW_TYPE_MSB:`IW_TYPE_LSB] == `TYPE_3)   // RL7
              p = p + (w[`IW_THREE] ? 4'd3 : 4'd2);
            else
              p = p + 4'd1;
            // set closes on end mark, flow change or type 4
            if (w[`IW_END] || ctl ||
                w[`IW_TYPE_MSB:`IW_TYPE_LSB] == `TYPE_4)   // RL7
              done = 1'b1;
          end
        end
      end
      if (p > 4'd8)
        p = 4'd8;
      scan_set = {ctl, cpos, cnt, p};
    end
  endfunction

  wire [10:0]     sc      = scan_set(cur_reg, ptr_reg);    // RL4
  wire            sc_ctl  = sc[10];
  wire [15:0]     cw      = cur_reg[sc[9:7]*16 +: 16];
  wire [1:0]      cop     = cw[`IW_OP_MSB:`IW_OP_LSB];
  wire [1:0]      lidx    = cw[1:0];
  wire [PC_W-1:0] seq_pc  = cur_addr_reg + {{(PC_W-4){1'b0}}, sc[3:0]};
  wire [PC_W-1:0] jmp_pc  = {{(PC_W-10){1'b0}}, cw[`IW_TGT_MSB:0], 3'b000};
  wire [SP_W-1:0] sp_act  = sr_reg[`SR_EXC] ? esp_reg : nsp_reg; // RL14

  // ***********************************************
  // flow decisions at dispatch
  // ***********************************************
  reg            redirect;
  reg [PC_W-1:0] tgt;
  reg            do_call;
  reg            do_rts;
  wire dispatch = run_reg && cur_ok_reg && !ret_wait_reg && sc[6:4] != 3'd0;

  // change of flow replaces the sequential fetch stream
  always @*
  begin
    redirect = 1'b0;
    tgt = seq_pc;
    do_call = 1'b0;
    do_rts = 1'b0;
    if (dispatch && sc_ctl)
    begin
      case (cop)
        `OP_JMP:
        begin
          redirect = 1'b1;
          tgt = jmp_pc;
        end
        `OP_CALL:
        begin
          redirect = 1'b1;
          tgt = jmp_pc;
          do_call = 1'b1;
        end
        `OP_RTS:
        begin
          do_rts = 1'b1;
          redirect = 1'b1;
          tgt = ras_reg;                                   // RL18
        end
        `OP_LOOP:
        begin
          // loop end jumps back while more than one pass remains
          if (cw[`IW_LOOP_END] && sr_reg[lidx] && lc_reg[lidx] > 1)
          begin
            redirect = 1'b1;
            tgt = ls_reg[lidx];                            // RL10
          end
        end
        default:
          redirect = 1'b0;
      endcase
    end
  end

  wire flush    = redirect || !run_reg || ret_wait_reg;
  wire cur_done = dispatch && sc[3:0] >= 4'd8;
  assign fetch_req  = run_reg && !out_reg && !nxt_ok_reg && !flush; // RL2
  assign fetch_addr = {pc_reg[PC_W-1:3], 3'b000};          // RL3

  // ***********************************************
  // prefetch, fetch and dispatch stages
  // ***********************************************
  // prefetch waits while a fetch is outstanding or the fetch buffer is full; hazards are software's
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_reg       <= {PC_W{1'b0}};
      req_addr_reg <= {PC_W{1'b0}};
      out_reg      <= 1'b0;
      kill_reg     <= 1'b0;
      nxt_reg      <= 128'h0;
      nxt_ok_reg   <= 1'b0;
      nxt_addr_reg <= {PC_W{1'b0}};
      cur_reg      <= 128'h0;
      cur_ok_reg   <= 1'b0;
      cur_addr_reg <= {PC_W{1'b0}};
      ptr_reg      <= 4'h0;
    end
    else
    begin
      // stage one: prefetch issues the next aligned fetch set
      if (fetch_req)
      begin
        out_reg      <= 1'b1;
        req_addr_reg <= pc_reg;
        pc_reg       <= {pc_reg[PC_W-1:3] + 1'b1, 3'b000}; // RL3
      end
      // stage two: fetch captures the 128 bit set
      if (fetch_rvalid && out_reg)
      begin
        out_reg <= 1'b0;
        if (kill_reg || flush)
          kill_reg <= 1'b0;
        else
        begin
          nxt_reg      <= fetch_rdata;                     // RL2
          nxt_ok_reg   <= 1'b1;
          nxt_addr_reg <= req_addr_reg;
        end
      end
      // stage three: dispatch steps through the current set
      if (flush)
      begin
        cur_ok_reg <= 1'b0;
        nxt_ok_reg <= 1'b0;
        kill_reg   <= out_reg && !fetch_rvalid;
        if (!run_reg)
          pc_reg <= start_reg;
        else if (redirect)
          pc_reg <= tgt;
        else if (ret_wait_reg)
          pc_reg <= stk_rdata[PC_W-1:0];                   // RL21
      end
      else if ((!cur_ok_reg || cur_done) && nxt_ok_reg)
      begin
        cur_reg      <= nxt_reg;                           // RL4
        cur_ok_reg   <= 1'b1;
        cur_addr_reg <= {nxt_addr_reg[PC_W-1:3], 3'b000};
        ptr_reg      <= {1'b0, nxt_addr_reg[2:0]};
        nxt_ok_reg   <= 1'b0;
      end
      else if (cur_done)
        cur_ok_reg <= 1'b0;
      else if (dispatch)
        ptr_reg <= sc[3:0];
    end
  end

  // ***********************************************
  // dispatch, address generation and execution
  // ***********************************************
  // one set per cycle moves down, never held back
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      disp_valid <= 1'b0;
      disp_set   <= 128'h0;
      disp_start <= 3'h0;
      disp_count <= 3'h0;
      agen_valid <= 1'b0;
      agen_count <= 3'h0;
      exec_valid <= 1'b0;
      exec_count <= 3'h0;
    end
    else
    begin
      disp_valid <= dispatch;                              // RL1
      if (dispatch)
      begin
        disp_set   <= cur_reg;
        disp_start <= ptr_reg[2:0];
        disp_count <= sc[6:4];                             // RL6
      end
      agen_valid <= disp_valid;                            // RL5
      agen_count <= disp_count;
      exec_valid <= agen_valid;                            // RL5
      exec_count <= agen_count;                            // RL9
    end
  end

  // ***********************************************
  // stacks, return address and loops
  // ***********************************************
  wire apb_wr = psel && penable && pwrite;
  wire [SP_W-1:0] sp_dec = sp_act - 1'b1;

  stack_mem #(
    .W  (SW),
    .AW (SP_W)
  ) u_stack (
    .clk   (pclk),
    .we    (do_call),                                      // RL15
    .waddr (sp_act),
    .wdata ({sr_reg, seq_pc}),                             // RL15
    .raddr (sp_dec),
    .rdata (stk_rdata)
  );

  // apb writes first; the sequencer's own updates win a tie
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_reg      <= 1'b0;
      start_reg    <= {PC_W{1'b0}};
      sr_reg       <= `SR_RESET;
      nsp_reg      <= {SP_W{1'b0}};
      esp_reg      <= {SP_W{1'b0}};
      ras_reg      <= {PC_W{1'b0}};
      ras_ok_reg   <= 1'b0;
      ret_wait_reg <= 1'b0;
      ret_sr_reg   <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
      begin
        lc_reg[i] <= {LC_W{1'b0}};
        ls_reg[i] <= {PC_W{1'b0}};
      end
    end
    else
    begin
      if (apb_wr)
      begin
        case (paddr)
          `OFS_CTRL:  run_reg   <= pwdata[0];
          `OFS_SR:    sr_reg    <= pwdata[`SR_W-1:0];
          `OFS_START: start_reg <= pwdata[PC_W-1:0];
          `OFS_NSP:   nsp_reg   <= pwdata[SP_W-1:0];       // RL13
          `OFS_ESP:   esp_reg   <= pwdata[SP_W-1:0];       // RL13
          default:    ;
        endcase
        if (paddr[7:4] == `OFS_LC_BASE)
          lc_reg[paddr[3:2]] <= pwdata[LC_W-1:0];          // RL11
      end
      ret_wait_reg <= 1'b0;
      ret_sr_reg   <= 1'b0;
      // status comes back one cycle after the return
      if (ret_wait_reg || ret_sr_reg)
        sr_reg <= stk_rdata[SW-1:PC_W];                    // RL16
      if (do_call)
      begin
        if (sr_reg[`SR_EXC])
          esp_reg <= sp_act + 1'b1;
        else
          nsp_reg <= sp_act + 1'b1;
        ras_reg    <= seq_pc;                              // RL17
        ras_ok_reg <= 1'b1;
      end
      if (do_rts)
      begin
        if (sr_reg[`SR_EXC])
          esp_reg <= sp_dec;                               // RL18
        else
          nsp_reg <= sp_dec;
        // an outer return falls back on the stacked address
        ras_ok_reg <= 1'b0;                                // RL19
        if (ras_ok_reg)
          ret_sr_reg <= 1'b1;
        else
          ret_wait_reg <= 1'b1;                            // RL21
      end
      // loop start records body address; software keeps index order
      if (dispatch && sc_ctl && cop == `OP_LOOP)
      begin
        if (!cw[`IW_LOOP_END])
        begin
          ls_reg[lidx] <= seq_pc;                          // RL11
          sr_reg[lidx] <= 1'b1;                            // RL10
        end
        else if (sr_reg[lidx] && lc_reg[lidx] > 1)
          lc_reg[lidx] <= lc_reg[lidx] - 1'b1;             // RL10
        else if (sr_reg[lidx])
        begin
          sr_reg[lidx]          <= 1'b0;                   // RL11
          sr_reg[`SR_LOOP_DONE] <= 1'b1;
        end
      end
    end
  end

  // ***********************************************
  // apb read port
  // ***********************************************
  wire rd_lc = paddr[7:4] == `OFS_LC_BASE;
  wire rd_ls = paddr[7:4] == `OFS_LS_BASE;
  wire hit   = paddr == `OFS_CTRL || paddr == `OFS_SR ||
               paddr == `OFS_START || paddr == `OFS_NSP ||
               paddr == `OFS_ESP || paddr == `OFS_RAS ||
               paddr == `OFS_STAT || rd_lc || rd_ls;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // read data latched in the setup cycle, zero wait states
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable)
    begin
      prdata <= 32'h00000000;
      case (paddr)
        `OFS_CTRL:  prdata[0] <= run_reg;
        `OFS_SR:    prdata[`SR_W-1:0] <= sr_reg;
        `OFS_START: prdata[PC_W-1:0] <= start_reg;
        `OFS_NSP:   prdata[SP_W-1:0] <= nsp_reg;
        `OFS_ESP:   prdata[SP_W-1:0] <= esp_reg;
        `OFS_RAS:   prdata[PC_W:0] <= {ras_ok_reg, ras_reg};
        `OFS_STAT:  prdata[3:0] <= {ret_wait_reg, out_reg,
                                    nxt_ok_reg, cur_ok_reg};
        default:
        begin
          if (rd_lc)
            prdata[LC_W-1:0] <= lc_reg[paddr[3:2]];
          else if (rd_ls)
            prdata[PC_W-1:0] <= ls_reg[paddr[3:2]];
        end
      endcase
    end
  end
endmodule

// ### program_sequencer_props.sv
// checker for the program sequencer ports
`timescale 1ns/1ps
// ****************
// port checker
// ****************
module program_sequencer_props #(
  parameter PC_W = 16
) (
  input wire            pclk,           // clock
  input wire            presetn,        // reset
  input wire            psel,           // select
  input wire            penable,        // enable
  input wire            pwrite,         // write
  input wire [7:0]      paddr,          // address
  input wire [31:0]     pwdata,         // write data
  input wire            fetch_req,      // fetch request
  input wire [PC_W-1:0] fetch_addr,     // fetch address
  input wire            disp_valid,     // dispatch
  input wire [2:0]      disp_start,     // first word
  input wire [2:0]      disp_count,     // set size
  input wire            agen_valid,     // stage four
  input wire [2:0]      agen_count,     // stage four size
  input wire            exec_valid,     // stage five
  input wire [2:0]      exec_count,     // stage five size
  input wire            exception_mode  // active stack select
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // each stage takes one cycle; none holds a set back
  a_agen_follows: assert property (disp_valid |=> agen_valid &&
    agen_count == $past(disp_count)) else $error("agen lost dispatch");
  a_exec_follows: assert property (agen_valid |=> exec_valid &&
    exec_count == $past(agen_count)) else $error("exec lost agen");
  a_no_interlock: assert property (disp_valid |-> ##2 exec_valid &&
    exec_count == $past(disp_count, 2)) else $error("pipeline stalled");
  a_count_range: assert property (disp_valid |->
    disp_count >= 3'd1 && disp_count <= 3'd6) else $error("bad set size");
  a_set_bound: assert property (disp_valid |->
    ({1'b0, disp_start} + {1'b0, disp_count}) <= 4'd8)
    else $error("set crosses fetch set");
  a_fetch_align: assert property (fetch_req |->
    fetch_addr[2:0] == 3'd0) else $error("fetch not aligned");
  a_fetch_pulse: assert property (fetch_req |=> !fetch_req)
    else $error("fetch request held");
  a_mode_bit: assert property (psel && penable && pwrite &&
    paddr == 8'h04 |=> exception_mode == $past(pwdata[5]))
    else $error("mode bit not taken");
  c_full_set: cover property (disp_valid && disp_count == 3'd6);
  c_exc_fetch: cover property (exception_mode && fetch_req);
  c_unmapped: cover property (psel && penable && paddr == 8'h40);
endmodule
bind program_sequencer program_sequencer_props #(.PC_W(PC_W)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .fetch_req(fetch_req), .fetch_addr(fetch_addr),
  .disp_valid(disp_valid), .disp_start(disp_start),
  .disp_count(disp_count), .agen_valid(agen_valid),
  .agen_count(agen_count), .exec_valid(exec_valid),
  .exec_count(exec_count), .exception_mode(exception_mode));

// ### prog_mem.sv
// program memory model
`timescale 1ns/1ps
// ****************
// program memory
// ****************
module prog_mem (
  input  wire         pclk,         // clock
  input  wire         presetn,      // reset
  input  wire         fetch_req,    // request
  input  wire [15:0]  fetch_addr,   // word address
  input  wire [3:0]   lat,          // extra wait cycles
  output reg  [127:0] fetch_rdata,  // fetch set
  output reg          fetch_rvalid  // data valid
);
  reg [127:0] rom [0:15];
  reg [127:0] last;
  reg [3:0]   cnt;
  reg [3:0]   idx;
  reg         busy;
  integer     i;
  // grouping, slots, loops, calls, returns
  initial
  begin
    for (i = 0; i < 16; i = i + 1)
      rom[i] = 128'h0;
    rom[0]  = {{6{16'h0000}}, 16'h8000, 16'h0000};
    rom[1]  = {{5{16'h6c04}}, 16'ha400, 16'h2800, 16'h2400};
    rom[4]  = {{6{16'h6c04}}, 16'h6f80, 16'h6f00};
    rom[6]  = {{7{16'h6c06}}, 16'h6d08};
    rom[8]  = {8{16'h6c08}};
    rom[10] = {{7{16'h6c0a}}, 16'h6d0c};
    rom[12] = {8{16'h6e00}};
  end
  // idle bus shows the inverse of the last set
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy         <= 1'b0;
      fetch_rvalid <= 1'b0;
      fetch_rdata  <= 128'h0;
      last         <= 128'h0;
      cnt          <= 4'h0;
      idx          <= 4'h0;
    end
    else
    begin
      fetch_rvalid <= 1'b0;
      fetch_rdata  <= ~last;
      if (fetch_req && !busy)
      begin
        busy <= 1'b1;
        cnt  <= lat;
        idx  <= fetch_addr[6:3];
      end
      else if (busy && cnt != 4'h0)
        cnt <= cnt - 4'h1;
      else if (busy)
      begin
        busy         <= 1'b0;
        fetch_rvalid <= 1'b1;
        fetch_rdata  <= rom[idx];
        last         <= rom[idx];
      end
    end
  end
endmodule

// ### tb_program_sequencer.sv
// program sequencer testbench
`timescale 1ns/1ps
// ****************
// bench top
// ****************
module tb_program_sequencer;
  reg          pclk, presetn, psel, penable, pwrite, err, hit_rts, back;
  reg  [7:0]   paddr;
  reg  [31:0]  pwdata, rd;
  reg  [3:0]   lat;
  reg  [2:0]   d_start [0:7];
  reg  [2:0]   d_count [0:7];
  reg  [127:0] first_set;
  wire [31:0]  prdata;
  wire         pready, pslverr, fetch_req, fetch_rvalid;
  wire         disp_valid, agen_valid, exec_valid, exception_mode;
  wire [15:0]  fetch_addr;
  wire [127:0] fetch_rdata, disp_set;
  wire [2:0]   disp_start, disp_count, agen_count, exec_count;
  integer      fails, checks_done, ndisp;
  localparam [14:0] ES = {3'd3, 3'd2, 3'd0, 3'd2, 3'd0};
  localparam [14:0] EC = {3'd1, 3'd1, 3'd2, 3'd6, 3'd2};
  program_sequencer u_program_sequencer (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_rdata(fetch_rdata), .fetch_rvalid(fetch_rvalid),
    .disp_valid(disp_valid), .disp_set(disp_set),
    .disp_start(disp_start), .disp_count(disp_count),
    .agen_valid(agen_valid), .agen_count(agen_count),
    .exec_valid(exec_valid), .exec_count(exec_count),
    .exception_mode(exception_mode));
  prog_mem u_prog_mem (.pclk(pclk), .presetn(presetn),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .lat(lat),
    .fetch_rdata(fetch_rdata), .fetch_rvalid(fetch_rvalid));
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // records dispatches and the return
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ndisp = 0;
      hit_rts = 1'b0;
      back = 1'b0;
    end
    else
    begin
      if (disp_valid === 1'b1 && ndisp < 8)
      begin
        if (ndisp == 0)
          first_set = disp_set;
        d_start[ndisp] = disp_start;
        d_count[ndisp] = disp_count;
        ndisp = ndisp + 1;
      end
      if (fetch_req === 1'b1 && fetch_addr === 16'd96)
        hit_rts = 1'b1;
      else if (fetch_req === 1'b1 && hit_rts && fetch_addr === 16'd80)
        back = 1'b1;
    end
  end
  task check(input string name, input [31:0] seen, input [31:0] exp);
  begin
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("CHECK FAILED %0s exp %h seen %h", name, exp, seen);
    end
  end
  endtask
  // one apb transfer, held until pready
  task apb(input w, input [7:0] a, input [31:0] d);
  begin
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  task poll(input [7:0] a, input [31:0] e);
    integer k;
  begin
    k = 0;
    rd = ~e;
    while (rd !== e && k < 50)
    begin
      apb(1'b0, a, 32'h0);
      k = k + 1;
    end
  end
  endtask
  task do_reset;
  begin
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  end
  endtask
  task t_regs;
  begin
    apb(1'b0, 8'h04, 32'h0);
    check("sr", rd, 32'h0);
    apb(1'b1, 8'h14, 32'hffff);
    apb(1'b0, 8'h14, 32'h0);
    check("ras", rd, 32'h0);
    apb(1'b1, 8'h0c, 32'h55);
    apb(1'b0, 8'h0c, 32'h0);
    check("nsp", rd, 32'h55);
    apb(1'b1, 8'h10, 32'h66);
    apb(1'b0, 8'h10, 32'h0);
    check("esp", rd, 32'h66);
    apb(1'b1, 8'h20, 32'h3);
    apb(1'b0, 8'h20, 32'h0);
    check("lc0", rd, 32'h3);
    apb(1'b0, 8'h30, 32'h0);
    check("ls0", rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
  end
  endtask
  task t_mode;
  begin
    apb(1'b1, 8'h04, 32'h20);
    @(posedge pclk);
    check("mode on", {31'h0, exception_mode}, 32'h1);
    apb(1'b1, 8'h04, 32'h0);
    @(posedge pclk);
    check("mode off", {31'h0, exception_mode}, 32'h0);
  end
  endtask
  // fast and slow memory
  task t_dispatch(input [3:0] l);
    integer k;
  begin
    do_reset;
    lat <= l;
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h20, 32'h2);
    apb(1'b1, 8'h00, 32'h1);
    k = 0;
    while (ndisp < 5 && k < 300)
    begin
      @(posedge pclk);
      k = k + 1;
    end
    for (k = 0; k < 5; k = k + 1)
    begin
      check("start", {29'h0, d_start[k]}, {29'h0, ES[3*k +: 3]});
      check("count", {29'h0, d_count[k]}, {29'h0, EC[3*k +: 3]});
    end
    check("set0", first_set[31:0], 32'h8000_0000);
    poll(8'h20, 32'h1);
    check("lc", rd, 32'h1);
    apb(1'b0, 8'h30, 32'h0);
    check("ls", rd, 32'h21);
    apb(1'b1, 8'h00, 32'h0);
  end
  endtask
  task t_call_exc;
  begin
    do_reset;
    apb(1'b1, 8'h0c, 32'h10);
    apb(1'b1, 8'h10, 32'h20);
    apb(1'b1, 8'h04, 32'h20);
    apb(1'b1, 8'h08, 32'h30);
    apb(1'b1, 8'h00, 32'h1);
    poll(8'h10, 32'h21);
    check("esp push", rd, 32'h21);
    apb(1'b0, 8'h0c, 32'h0);
    check("nsp kept", rd, 32'h10);
    apb(1'b0, 8'h14, 32'h0);
    check("ras valid", {31'h0, rd[16]}, 32'h1);
    apb(1'b1, 8'h00, 32'h0);
  end
  endtask
  task t_return;
    integer k;
  begin
    do_reset;
    apb(1'b1, 8'h0c, 32'h10);
    apb(1'b1, 8'h08, 32'h50);
    apb(1'b1, 8'h00, 32'h1);
    k = 0;
    while (!back && k < 300)
    begin
      @(posedge pclk);
      k = k + 1;
    end
    check("returned", {31'h0, back}, 32'h1);
    poll(8'h0c, 32'h10);
    check("nsp pop", rd, 32'h10);
    apb(1'b1, 8'h00, 32'h0);
  end
  endtask
  task test_done;
  begin
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  // cuts a hang short
  initial
  begin
    repeat (20000) @(posedge pclk);
    fails = fails + 1;
    test_done;
  end
  initial
  begin
    fails = 0;
    checks_done = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lat = 4'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_mode;
    t_dispatch(4'h0);
    t_dispatch(4'h3);
    t_call_exc;
    t_return;
    test_done;
  end
endmodule
